// >>> core/hpw_device.sv
/*
 * Device end of the asynchronous 16-bit host write port. Detects the
 * cycle framed by select and write strobe, captures address and data
 * as the cycle ends and reports either a register write or a transmit
 * FIFO push for one clock.
 * Assumes bus pins are synchronous to i_clk (the host end drives them
 * from the same clock).
 */
// Functional notes
// - All writes use one cycle, either strobe frames
// - Cycle starts both low, ends either high
// - Host keeps 32ns active, 13ns idle, 45ns period
// - One 16-bit word per write cycle
// - Direct select ignores address, writes transmit FIFO
// - Direct writes share timing; select sampled like address
// - System may tie direct select to address line
`timescale 1ns/1ps
`default_nettype none
module hpw_device (
    input wire logic i_clk,
    input wire logic i_rst,
    hpw_if.device bus,
    output logic o_reg_wr,
    output logic [hpw_pkg::ADDR_W-1:0] o_reg_addr,
    output logic [hpw_pkg::DATA_W-1:0] o_reg_data,
    output logic o_fifo_wr,
    output logic [hpw_pkg::DATA_W-1:0] o_fifo_data
);
    logic active;
    logic next_active;
    logic [hpw_pkg::ADDR_W-1:0] addr_q;
    logic [hpw_pkg::ADDR_W-1:0] next_addr_q;
    logic [hpw_pkg::DATA_W-1:0] data_q;
    logic [hpw_pkg::DATA_W-1:0] next_data_q;
    logic sel_q;
    logic next_sel_q;
    logic next_reg_wr;
    logic next_fifo_wr;
    logic [hpw_pkg::ADDR_W-1:0] next_reg_addr;
    logic [hpw_pkg::DATA_W-1:0] next_reg_data;
    logic [hpw_pkg::DATA_W-1:0] next_fifo_data;
    logic both_low;

    // Either strobe may frame the cycle; only the AND of the two counts
    assign both_low = !bus.host_select_n && !bus.write_strobe_n;

    // Track the cycle and keep the last sampled bus while it is active;
    // the value held at the ending edge is what gets stored, so late data
    // still lands
    always_comb begin
        next_active = both_low;
        next_addr_q = addr_q;
        next_data_q = data_q;
        next_sel_q = sel_q;
        if (both_low) begin
            next_addr_q = bus.addr;
            next_data_q = bus.data;
            next_sel_q = bus.fifo_direct_sel;
        end
        next_reg_wr = 1'b0;
        next_fifo_wr = 1'b0;
        next_reg_addr = o_reg_addr;
        next_reg_data = o_reg_data;
        next_fifo_data = o_fifo_data;
        // First sample with either strobe high ends the cycle
        if (active && !both_low) begin
            if (sel_q) begin
                next_fifo_wr = 1'b1;
                next_fifo_data = data_q;
            end else begin
                next_reg_wr = 1'b1;
                next_reg_addr = addr_q;
                next_reg_data = data_q;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            active <= 1'b0;
            addr_q <= '0;
            data_q <= '0;
            sel_q <= 1'b0;
            o_reg_wr <= 1'b0;
            o_fifo_wr <= 1'b0;
            o_reg_addr <= '0;
            o_reg_data <= '0;
            o_fifo_data <= '0;
        end else begin
            active <= next_active;
            addr_q <= next_addr_q;
            data_q <= next_data_q;
            sel_q <= next_sel_q;
            o_reg_wr <= next_reg_wr;
            o_fifo_wr <= next_fifo_wr;
            o_reg_addr <= next_reg_addr;
            o_reg_data <= next_reg_data;
            o_fifo_data <= next_fifo_data;
        end
    end
endmodule
`default_nettype wire

// >>> core/hpw_host.sv
/*
 * Host end of the write port. Takes one write request at a time from
 * user logic and plays it out as a bus cycle meeting the least active,
 * idle and period times. Framing is by the write strobe with select
 * held low for the whole cycle.
 * Assumes the device end samples on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module hpw_host (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_req,
    input wire logic i_fifo_sel,
    input wire logic [hpw_pkg::ADDR_W-1:0] i_addr,
    input wire logic [hpw_pkg::DATA_W-1:0] i_data,
    output logic o_ready,
    hpw_if.host bus
);
    typedef enum logic [1:0] {
        HPW_IDLE = 2'b00,
        HPW_ACT = 2'b01,
        HPW_GAP = 2'b10
    } hpw_state_t;

    hpw_state_t state;
    hpw_state_t next_state;
    logic [hpw_pkg::CNT_W-1:0] cnt;
    logic [hpw_pkg::CNT_W-1:0] next_cnt;
    logic next_ready;
    logic next_sel_n;
    logic next_wr_n;
    logic next_fsel;
    logic [hpw_pkg::ADDR_W-1:0] next_addr;
    logic [hpw_pkg::DATA_W-1:0] next_data;
    logic [hpw_pkg::ADDR_W-1:0] addr_r;
    logic [hpw_pkg::DATA_W-1:0] data_r;
    logic sel_n_r;
    logic wr_n_r;
    logic fsel_r;

    assign bus.host_select_n = sel_n_r;
    assign bus.write_strobe_n = wr_n_r;
    assign bus.fifo_direct_sel = fsel_r;
    assign bus.addr = addr_r;
    assign bus.data = data_r;

    // Active for ASSERT_CYC, then idle long enough that both the idle
    // time and the full period are met
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_ready = o_ready;
        next_sel_n = sel_n_r;
        next_wr_n = wr_n_r;
        next_fsel = fsel_r;
        next_addr = addr_r;
        next_data = data_r;
        case (state)
            HPW_IDLE: begin
                if (i_req && o_ready) begin
                    // Address and direct select set up with the strobe
                    next_sel_n = 1'b0;
                    next_wr_n = 1'b0;
                    next_fsel = i_fifo_sel;
                    next_addr = i_addr;
                    next_data = i_data;
                    next_ready = 1'b0;
                    next_cnt = hpw_pkg::CNT_W'(hpw_pkg::ASSERT_CYC - 1);
                    next_state = HPW_ACT;
                end
            end
            HPW_ACT: begin
                if (cnt == hpw_pkg::CNT_ZERO) begin
                    next_wr_n = 1'b1;
                    next_sel_n = 1'b1;
                    next_cnt = hpw_pkg::CNT_W'(
                        (hpw_pkg::CYCLE_CYC - hpw_pkg::ASSERT_CYC >
                         hpw_pkg::DEASSERT_CYC ?
                         hpw_pkg::CYCLE_CYC - hpw_pkg::ASSERT_CYC :
                         hpw_pkg::DEASSERT_CYC) - 1);
                    next_state = HPW_GAP;
                end else begin
                    next_cnt = cnt - hpw_pkg::CNT_ONE;
                end
            end
            HPW_GAP: begin
                if (cnt == hpw_pkg::CNT_ZERO) begin
                    next_ready = 1'b1;
                    next_state = HPW_IDLE;
                end else begin
                    next_cnt = cnt - hpw_pkg::CNT_ONE;
                end
            end
            default: begin
                next_state = HPW_IDLE;
                next_ready = 1'b1;
                next_sel_n = 1'b1;
                next_wr_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= HPW_IDLE;
            cnt <= hpw_pkg::CNT_ZERO;
            o_ready <= 1'b1;
            sel_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            fsel_r <= 1'b0;
            addr_r <= '0;
            data_r <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            o_ready <= next_ready;
            sel_n_r <= next_sel_n;
            wr_n_r <= next_wr_n;
            fsel_r <= next_fsel;
            addr_r <= next_addr;
            data_r <= next_data;
        end
    end
endmodule
`default_nettype wire

// >>> core/hpw_if.sv
/*
 * Pin bundle between the host end and the device end of the write port.
 * Assumes one shared clock; all pins are driven by the host only.
 */
`timescale 1ns/1ps
`default_nettype none
interface hpw_if;
    logic host_select_n;
    logic write_strobe_n;
    logic fifo_direct_sel;
    logic [hpw_pkg::ADDR_W-1:0] addr;
    logic [hpw_pkg::DATA_W-1:0] data;
    modport host (
        output host_select_n, write_strobe_n, fifo_direct_sel, addr, data
    );
    modport device (
        input host_select_n, write_strobe_n, fifo_direct_sel, addr, data
    );
endinterface
`default_nettype wire

// >>> core/hpw_pkg.sv
/*
 * Shared constants for the host write port: bus widths, cycle timing
 * in ns and the derived counts of 100 MHz clock cycles.
 * Assumes both ends run on the same 10 ns clock.
 */
`default_nettype none
package hpw_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 7;
    // Least times round up to whole cycles
    localparam int T_ASSERT_NS = 32;
    localparam int T_DEASSERT_NS = 13;
    localparam int T_CYCLE_NS = 45;
    localparam int ASSERT_CYC =
        (T_ASSERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEASSERT_CYC =
        (T_DEASSERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYCLE_CYC =
        (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
endpackage
`default_nettype wire

// >>> tb/hpw_properties.sv
/* Checks on the write pins and device outputs.
   Assumes one clock for both ends, reset async high. */
`timescale 1ns/1ps
`default_nettype none
module hpw_properties (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic host_select_n,
    input wire logic write_strobe_n,
    input wire logic fifo_direct_sel,
    input wire logic [hpw_pkg::ADDR_W-1:0] addr,
    input wire logic [hpw_pkg::DATA_W-1:0] data,
    input wire logic o_reg_wr,
    input wire logic [hpw_pkg::ADDR_W-1:0] o_reg_addr,
    input wire logic [hpw_pkg::DATA_W-1:0] o_reg_data,
    input wire logic o_fifo_wr,
    input wire logic [hpw_pkg::DATA_W-1:0] o_fifo_data
);
    logic [hpw_pkg::ADDR_W-1:0] cap_addr;
    logic [hpw_pkg::DATA_W-1:0] cap_data;
    wire logic busy = !host_select_n && !write_strobe_n;
    // Last word while active; pins may move once the cycle ends
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cap_addr <= '0;
            cap_data <= '0;
        end else if (busy) begin
            cap_addr <= addr;
            cap_data <= data;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // First sample with either line high after an active one
    sequence s_end; $past(busy) && !busy; endsequence
    sequence s_end_f; s_end ##0 $past(fifo_direct_sel); endsequence
    sequence s_end_r; s_end ##0 !$past(fifo_direct_sel); endsequence
    property p_frame; host_select_n == write_strobe_n; endproperty
    a_frame: assert property (p_frame) else $error("split");
    property p_end; s_end |-> ##[1:2] (o_reg_wr || o_fifo_wr); endproperty
    a_end: assert property (p_end) else $error("no pulse");
    property p_fifo; s_end_f |-> ##[1:2] o_fifo_wr; endproperty
    a_fifo: assert property (p_fifo) else $error("no push");
    property p_reg; s_end_r |-> ##[1:2] o_reg_wr; endproperty
    a_reg: assert property (p_reg) else $error("no write");
    property p_fdat; o_fifo_wr |-> o_fifo_data == cap_data; endproperty
    a_fdat: assert property (p_fdat) else $error("push word");
    property p_rdat;
        o_reg_wr |-> o_reg_addr == cap_addr && o_reg_data == cap_data;
    endproperty
    a_rdat: assert property (p_rdat) else $error("reg word");
    property p_act; $fell(write_strobe_n) |-> busy[*4]; endproperty
    a_act: assert property (p_act) else $error("short");
    property p_idle; $rose(write_strobe_n) |-> write_strobe_n[*2]; endproperty
    a_idle: assert property (p_idle) else $error("gap");
    // No new cycle may start within the least period after a start
    property p_period;
        $fell(write_strobe_n) |=> (!$fell(write_strobe_n))[*4];
    endproperty
    a_period: assert property (p_period) else $error("period");
endmodule
`default_nettype wire

// >>> tb/tb.sv
/* Bench: host end drives device end over hpw_if.
   Assumes package, interface and both ends compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed {
        logic f;
        logic [hpw_pkg::ADDR_W-1:0] a;
        logic [hpw_pkg::DATA_W-1:0] d;
    } hpw_row_t;
    // Fifo rows carry an address that must be ignored; in the last one
    // the select follows address bit 6, as if tied to it
    localparam hpw_row_t ROWS [5] = '{'{1'b0, 7'h00, 16'h0000},
        '{1'b0, 7'h7f, 16'hffff}, '{1'b1, 7'h55, 16'ha5a5},
        '{1'b1, 7'h00, 16'h5a5a}, '{1'b1, 7'h41, 16'h3c3c}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0;
    logic fsel = 1'b0;
    logic [hpw_pkg::ADDR_W-1:0] addr = '0;
    logic [hpw_pkg::DATA_W-1:0] data = '0;
    logic ready, reg_wr, fifo_wr;
    logic [hpw_pkg::ADDR_W-1:0] reg_addr;
    logic [hpw_pkg::DATA_W-1:0] reg_data, fifo_data;
    int num_errors = 0;
    int cmp_count = 0;
    hpw_if hpw_if_i ();
    hpw_host hpw_host_i (.i_clk(clk), .i_rst(rst), .i_req(req),
        .i_fifo_sel(fsel), .i_addr(addr), .i_data(data), .o_ready(ready),
        .bus(hpw_if_i));
    hpw_device hpw_device_i (.i_clk(clk), .i_rst(rst), .bus(hpw_if_i),
        .o_reg_wr(reg_wr), .o_reg_addr(reg_addr), .o_reg_data(reg_data),
        .o_fifo_wr(fifo_wr), .o_fifo_data(fifo_data));
    hpw_properties hpw_properties_i (.i_clk(clk), .i_rst(rst),
        .host_select_n(hpw_if_i.host_select_n),
        .write_strobe_n(hpw_if_i.write_strobe_n),
        .fifo_direct_sel(hpw_if_i.fifo_direct_sel), .addr(hpw_if_i.addr),
        .data(hpw_if_i.data), .o_reg_wr(reg_wr), .o_reg_addr(reg_addr),
        .o_reg_data(reg_data), .o_fifo_wr(fifo_wr),
        .o_fifo_data(fifo_data));
    // 100 MHz clock
    always #5 clk = ~clk;
    task automatic check(input string n, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic conclude();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // One request; pins and answer are read as sampled at each edge
    task automatic wr(input hpw_row_t r);
        int lo;
        int n;
        logic [hpw_pkg::DATA_W-1:0] wd;
        lo = 0;
        n = 0;
        wd = '0;
        while (ready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        req <= 1'b1;
        fsel <= r.f;
        addr <= r.a;
        data <= r.d;
        @(posedge clk);
        req <= 1'b0;
        while (!(reg_wr === 1'b1 || fifo_wr === 1'b1) && n < 40) begin
            @(posedge clk);
            n++;
            if (hpw_if_i.write_strobe_n === 1'b0) begin
                lo++;
                wd = hpw_if_i.data;
            end
        end
        // A run-out wait counts as a mismatch of its own
        check("answered", n < 40, 1'h1);
        check("low cycles", lo, hpw_pkg::ASSERT_CYC);
        check("wire data", wd, r.d);
        check("push", fifo_wr, r.f);
        check("reg write", reg_wr, !r.f);
        check("word", r.f ? fifo_data : reg_data, r.d);
        if (!r.f) begin
            check("addr", reg_addr, r.a);
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        check("in reset", {ready, hpw_if_i.write_strobe_n}, 2'h3);
        rst <= 1'b0;
        foreach (ROWS[i]) wr(ROWS[i]);
        // Reset inside an active cycle must drop the word
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b1;
        repeat (9) begin
            @(posedge clk);
            check("abort",
                {reg_wr, fifo_wr, hpw_if_i.host_select_n}, 3'h1);
        end
        rst <= 1'b0;
        wr(ROWS[2]);
        conclude();
    end
    // Traffic needs about 60 cycles; this margin only catches a hang
    initial begin
        #20000;
        num_errors++;
        conclude();
    end
endmodule
`default_nettype wire
